// *** rsc_analog_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rsc_analog_model
(
	input  wire logic       clk_sys,
	input  wire logic [4:0] want,
	input  wire logic       slow,
	output logic      [4:0] req
);
	logic [4:0] lag_q;
	initial req = 5'h0;
	initial lag_q = 5'h0;
	// a slow peripheral raises and drops its request one cycle late
	always @(posedge clk_sys)
	begin
		lag_q <= want;
		req <= slow ? lag_q : want;
	end
endmodule
`default_nettype wire

// *** rsc_pkg.sv ***
package rsc_pkg;

	// register offsets (not all multiples of four, so these are word indices)
	localparam logic [1:0] RSC_IDX_SELECT_GROUP0 = 2'h0;
	localparam logic [1:0] RSC_IDX_FORCE_ENABLE  = 2'h1;
	localparam logic [1:0] RSC_IDX_SELECT_GROUP1 = 2'h2;
	localparam logic [1:0] RSC_IDX_SELECT_GROUP2 = 2'h3;

	// byte address is four times the index; bit 4 set marks unmapped space
	localparam int RSC_ADDR_W     = 5;
	localparam int RSC_IDX_LSB    = 2;
	localparam int RSC_REG_W      = 8;
	localparam int RSC_LEVEL_W    = 3;

	// field positions
	localparam int RSC_CONV_SEL_LSB = 4;
	localparam int RSC_OUT_SEL_LSB  = 0;
	localparam int RSC_OUT0_FORCE   = 0;
	localparam int RSC_CONV0_FORCE  = 1;
	localparam int RSC_OUT1_FORCE   = 3;
	localparam int RSC_CONV1_FORCE  = 4;
	localparam int RSC_OUT2_FORCE   = 5;

	// writable bit masks; all other bits read as zero
	localparam logic [7:0] RSC_MASK_SELECT = 8'h77;
	localparam logic [7:0] RSC_MASK_FORCE  = 8'h3B;
	localparam logic [7:0] RSC_MASK_GROUP2 = 8'h07;

	localparam logic [7:0] RSC_RESET_VALUE = 8'h00;

	// level codes
	localparam logic [2:0] RSC_LEVEL_0V55 = 3'h0;
	localparam logic [2:0] RSC_LEVEL_1V1  = 3'h1;
	localparam logic [2:0] RSC_LEVEL_2V5  = 3'h2;
	localparam logic [2:0] RSC_LEVEL_4V3  = 3'h3;
	localparam logic [2:0] RSC_LEVEL_1V5  = 3'h4;

	localparam logic [1:0] RSC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;

endpackage

// *** rsc_ref_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module rsc_ref_checker
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        conv0_request,
	input wire logic        out2_request,
	input wire logic        conv0_source_on,
	input wire logic        out2_source_on,
	input wire logic [2:0]  out0_level_select,
	input wire logic [2:0]  out2_level_select
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [1:0] age_q;
	// requests cross a two-flop synchroniser, so history is only valid three edges on
	always_ff @(posedge clk_sys)
		if (sys_rst)
			age_q <= 2'h0;
		else if (age_q != 2'h3)
			age_q <= age_q + 2'h1;
	property p_c0; age_q == 2'h3 && $past(conv0_request, 3) |-> conv0_source_on; endproperty
	a_c0: assert property (p_c0) else $error("conv0 source off while requested");
	property p_o2; age_q == 2'h3 && $past(out2_request, 3) |-> out2_source_on; endproperty
	a_o2: assert property (p_o2) else $error("out2 source off while requested");
	property p_off; age_q == 2'h3 && $fell(conv0_source_on) |-> !$past(conv0_request, 3); endproperty
	a_off: assert property (p_off) else $error("conv0 source dropped under request");
	property p_frc;
		age_q == 2'h3 && $rose(out2_source_on)
			|-> $past(out2_request, 3) || ($past(s_axi_bvalid) && !$past(s_axi_bvalid, 2));
	endproperty
	a_frc: assert property (p_frc) else $error("out2 source on without cause");
	property p_rst; $past(sys_rst) |-> out0_level_select == 3'h0 && out2_level_select == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("level not zero after reset");
	property p_lv; $changed(out0_level_select) |-> $rose(s_axi_bvalid); endproperty
	a_lv: assert property (p_lv) else $error("out0 level moved without write");
	property p_l2; $changed(out2_level_select) |-> $rose(s_axi_bvalid); endproperty
	a_l2: assert property (p_l2) else $error("out2 level moved without write");
	// no register has both bit 3 and bit 2 writable
	property p_rd;
		s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0 && !(s_axi_rdata[3] && s_axi_rdata[2]);
	endproperty
	a_rd: assert property (p_rd) else $error("unused read bits set");
	c_wr: cover property ($rose(s_axi_bvalid));
	c_req: cover property ($rose(conv0_source_on));
	c_frc: cover property (out2_source_on && !out2_request);
endmodule
bind rsc_reference_select_control rsc_ref_checker u_chk (.*);
`default_nettype wire

// *** rsc_reference_select_control.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - by default each reference source turns on when its peripheral requests it.
// - all level fields reset to code zero, the 0.55 volt setting.
// - first converter level in bits 6:4 at 0x00; codes 0-4 valid.
// - first output/comparator level in bits 2:0 at 0x00.
// - second converter level in bits 6:4 at 0x02.
// - second output/comparator level in bits 2:0 at 0x02.
// - third output/comparator level in bits 2:0 at 0x03; rest unused.
// - force bit 5 at 0x01 keeps third output source running.
// - force bit 4 keeps second converter source running.
// - force bit 3 keeps second output source running.
// - force bit 1 keeps first converter source running.
// - force bit 0 keeps first output source running.
// - force bit zero leaves source following its request.
module rsc_reference_select_control
	import rsc_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	input  wire logic [RSC_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [RSC_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   conv0_request,
	input  wire logic                   conv1_request,
	input  wire logic                   out0_request,
	input  wire logic                   out1_request,
	input  wire logic                   out2_request,
	output logic                        conv0_source_on,
	output logic                        conv1_source_on,
	output logic                        out0_source_on,
	output logic                        out1_source_on,
	output logic                        out2_source_on,
	output logic [RSC_LEVEL_W-1:0]      conv0_level_select,
	output logic [RSC_LEVEL_W-1:0]      conv1_level_select,
	output logic [RSC_LEVEL_W-1:0]      out0_level_select,
	output logic [RSC_LEVEL_W-1:0]      out1_level_select,
	output logic [RSC_LEVEL_W-1:0]      out2_level_select
);

	logic [7:0]            group0_q;
	logic [7:0]            force_q;
	logic [7:0]            group1_q;
	logic [7:0]            group2_q;
	logic                  aw_held_q;
	logic                  w_held_q;
	logic [RSC_ADDR_W-1:0] awaddr_q;
	logic [7:0]            wdata_q;
	logic                  wstrb0_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  rvalid_q;
	logic [1:0]            rresp_q;
	logic [31:0]           rdata_q;
	logic [4:0]            req_s1_q;
	logic [4:0]            req_s2_q;
	logic                  wr_fire;
	logic [1:0]            wr_idx;
	logic                  wr_ok;
	logic [1:0]            rd_idx;
	logic                  rd_ok;

	// write channel: address and data caught independently, in either order
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
	assign wr_idx        = awaddr_q[RSC_IDX_LSB +: 2];
	// only the first four words are mapped; the top address bit gives an error
	assign wr_ok         = awaddr_q[RSC_ADDR_W-1] == 1'b0;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end
		else if (wr_fire)
		begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb0_q <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata[7:0];
			wstrb0_q <= s_axi_wstrb[0];
		end
		else if (wr_fire)
		begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= RSC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_ok ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// register bank; byte lane 0 carries the data, masks drop unused bits
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			group0_q <= RSC_RESET_VALUE;
		end
		else if (wr_fire && wr_ok && wstrb0_q && wr_idx == RSC_IDX_SELECT_GROUP0)
		begin
			group0_q <= wdata_q & RSC_MASK_SELECT;
		end
	end

	// force bits take effect one edge after the write, with no synchroniser
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			force_q <= RSC_RESET_VALUE;
		end
		else if (wr_fire && wr_ok && wstrb0_q && wr_idx == RSC_IDX_FORCE_ENABLE)
		begin
			force_q <= wdata_q & RSC_MASK_FORCE;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			group1_q <= RSC_RESET_VALUE;
		end
		else if (wr_fire && wr_ok && wstrb0_q && wr_idx == RSC_IDX_SELECT_GROUP1)
		begin
			group1_q <= wdata_q & RSC_MASK_SELECT;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			group2_q <= RSC_RESET_VALUE;
		end
		else if (wr_fire && wr_ok && wstrb0_q && wr_idx == RSC_IDX_SELECT_GROUP2)
		begin
			group2_q <= wdata_q & RSC_MASK_GROUP2;
		end
	end

	// read channel: one cycle from address accept to data valid
	assign s_axi_arready = !rvalid_q;
	assign rd_idx        = s_axi_araddr[RSC_IDX_LSB +: 2];
	assign rd_ok         = s_axi_araddr[RSC_ADDR_W-1] == 1'b0;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= RSC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_ok ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			rvalid_q <= 1'b0;
		end
	end

	// read data is captured once per accepted address and then held
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rdata_q <= '0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			if (!rd_ok)
			begin
				rdata_q <= '0;
			end
			else if (rd_idx == RSC_IDX_SELECT_GROUP0)
			begin
				rdata_q <= {24'h000000, group0_q};
			end
			else if (rd_idx == RSC_IDX_FORCE_ENABLE)
			begin
				rdata_q <= {24'h000000, force_q};
			end
			else if (rd_idx == RSC_IDX_SELECT_GROUP1)
			begin
				rdata_q <= {24'h000000, group1_q};
			end
			else
			begin
				rdata_q <= {24'h000000, group2_q};
			end
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;

	// requests come from analog blocks on other clocks, so two flops first
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			req_s1_q <= '0;
			req_s2_q <= '0;
		end
		else
		begin
			req_s1_q <= {out2_request, conv1_request, out1_request,
				conv0_request, out0_request};
			req_s2_q <= req_s1_q;
		end
	end

	// source enables registered so outputs are glitch free toward the analog side
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			out0_source_on <= 1'b0;
		end
		else
		begin
			out0_source_on <= req_s2_q[0] | force_q[RSC_OUT0_FORCE];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			conv0_source_on <= 1'b0;
		end
		else
		begin
			conv0_source_on <= req_s2_q[1] | force_q[RSC_CONV0_FORCE];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			out1_source_on <= 1'b0;
		end
		else
		begin
			out1_source_on <= req_s2_q[2] | force_q[RSC_OUT1_FORCE];
		end
	end

	// forcing trades start-up time for standing power; software picks
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			conv1_source_on <= 1'b0;
		end
		else
		begin
			conv1_source_on <= req_s2_q[3] | force_q[RSC_CONV1_FORCE];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			out2_source_on <= 1'b0;
		end
		else
		begin
			out2_source_on <= req_s2_q[4] | force_q[RSC_OUT2_FORCE];
		end
	end

	// level codes pass unchanged; reserved codes are not filtered
	assign conv0_level_select = group0_q[RSC_CONV_SEL_LSB +: RSC_LEVEL_W];
	assign out0_level_select  = group0_q[RSC_OUT_SEL_LSB +: RSC_LEVEL_W];
	assign conv1_level_select = group1_q[RSC_CONV_SEL_LSB +: RSC_LEVEL_W];
	assign out1_level_select  = group1_q[RSC_OUT_SEL_LSB +: RSC_LEVEL_W];
	assign out2_level_select  = group2_q[RSC_OUT_SEL_LSB +: RSC_LEVEL_W];

endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rsc_pkg::*;
	logic        clk_sys, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow;
	logic        conv0_source_on, conv1_source_on, out0_source_on, out1_source_on, out2_source_on;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, q, s;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  conv0_level_select, conv1_level_select, out0_level_select;
	logic [2:0]  out1_level_select, out2_level_select;
	logic [4:0]  want, req;
	logic [7:0]  d, sh [4];
	int          i, k, miscompares, samples_checked;
	rsc_reference_select_control DUT (.*, .conv0_request(req[4]), .conv1_request(req[3]),
		.out0_request(req[2]), .out1_request(req[1]), .out2_request(req[0]));
	rsc_analog_model u_model (.clk_sys(clk_sys), .want(want), .slow(slow), .req(req));
	always #25 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	function automatic logic [7:0] msk(input int k);
		return (k == 1) ? RSC_MASK_FORCE : (k == 3) ? RSC_MASK_GROUP2 : RSC_MASK_SELECT;
	endfunction
	task automatic summarize();
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input int k, input logic [7:0] d);
		int n;
		logic a, w, b;
		b = 1'h0;
		@(posedge clk_sys);
		s_axi_awaddr <= 5'(k * 4);
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 50 && !b; n++)
		begin
			// sample between edges: these are the values the next rising edge sees
			@(negedge clk_sys);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			if (b) chk(32'(s_axi_bresp), 32'h0);
			@(posedge clk_sys);
			if (a) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) s_axi_bready <= 1'h0;
		end
		if (!b)
		begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic rd(input int k, output logic [31:0] v);
		int n;
		logic a, b;
		b = 1'h0;
		v = 32'h0;
		@(posedge clk_sys);
		s_axi_araddr <= 5'(k * 4);
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 50 && !b; n++)
		begin
			@(negedge clk_sys);
			a = s_axi_arvalid && s_axi_arready;
			b = s_axi_rvalid;
			if (b)
			begin
				v = s_axi_rdata;
				chk(32'(s_axi_rresp), 32'h0);
			end
			@(posedge clk_sys);
			if (a) s_axi_arvalid <= 1'h0;
			if (b) s_axi_rready <= 1'h0;
		end
		if (!b)
		begin
			miscompares++;
			summarize();
		end
	endtask
	initial
	begin
		{clk_sys, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, want, slow} = 48'h0;
		s_axi_wstrb = 4'hF;
		sys_rst = 1'h1;
		s = 32'h4E5A;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'h0;
		for (i = 0; i < 4; i++)
		begin
			rd(i, q);
			chk(q, 32'h0);
			sh[i] = 8'h0;
		end
		// first every level code, then all ones into each register, then random
		for (i = 0; i < 24; i++)
		begin
			k = (i < 5) ? 0 : (i < 9) ? i - 5 : int'(xs() % 4);
			d = (i < 5) ? {1'h1, 3'(i), 1'h1, 3'(i)} : (i < 9) ? 8'hFF : 8'(xs());
			wr(k, d);
			sh[k] = d & msk(k);
			rd(k, q);
			chk(q, {24'h0, sh[k]});
			chk({conv0_level_select, out0_level_select, conv1_level_select, out1_level_select,
				out2_level_select}, {sh[0][6:4], sh[0][2:0], sh[2][6:4], sh[2][2:0],
				sh[3][2:0]});
		end
		// force cleared first so the sources must follow requests alone
		for (i = 0; i < 16; i++)
		begin
			d = (i < 2) ? 8'h00 : 8'(xs());
			wr(1, d);
			sh[1] = d & msk(1);
			want <= 5'(xs());
			slow <= i[0];
			repeat (8) @(posedge clk_sys);
			chk({conv0_source_on, conv1_source_on, out0_source_on, out1_source_on, out2_source_on},
				want | {sh[1][1], sh[1][4], sh[1][0], sh[1][3], sh[1][5]});
		end
		summarize();
	end
endmodule
`default_nettype wire
